// file: rtl/fsp_guard_mem.v
`timescale 1ns/1ns
`include "fsp_map.vh"

// Per-sector guard bits: bit 1 persistent, bit 0 dynamic.
// Storage has no reset; the persistent half must survive hardware reset.
module fsp_guard_mem (
    input wire clk,
    input wire ce,
    input wire we,
    input wire [1:0] wmask,
    input wire [`FSP_SEC_W-1:0] waddr,
    input wire [1:0] wdata,
    input wire [`FSP_SEC_W-1:0] raddr,
    output reg [1:0] rdata
);

reg [1:0] cells [0:(1<<`FSP_SEC_W)-1];

genvar b;
generate
    for (b = 0; b < 2; b = b + 1)
    begin : g_bit
        always @(posedge clk)
        begin
            if (ce && we && wmask[b])
                cells[waddr][b] <= wdata[b];
        end
    end
endgenerate

always @(posedge clk)
begin
    if (ce)
        rdata <= cells[raddr];
end

endmodule

// file: rtl/fsp_map.vh
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// Sector and bank geometry
`define FSP_SEC_W 9
`define FSP_SEC_LAST 9'h1ff
`define FSP_BANK_W 4
`define FSP_BANK0 4'h0

// Decoded protection commands from the command-sequence front end
`define FSP_OP_EXIT 4'h0
`define FSP_OP_ENTER_LOCK 4'h1
`define FSP_OP_LOCK_PROG 4'h2
`define FSP_OP_LOCK_READ 4'h3
`define FSP_OP_ENTER_PPB 4'h4
`define FSP_OP_PPB_PROG 4'h5
`define FSP_OP_PPB_ERASE 4'h6
`define FSP_OP_PPB_READ 4'h7
`define FSP_OP_ENTER_DYB 4'h8
`define FSP_OP_DYB_SET 4'h9
`define FSP_OP_DYB_CLR 4'ha
`define FSP_OP_DYB_READ 4'hb
`define FSP_OP_ENTER_FRZ 4'hc
`define FSP_OP_FRZ_SET 4'hd
`define FSP_OP_FRZ_READ 4'he
`define FSP_OP_ARRAY_PE 4'hf

// Command modes
`define FSP_MD_READ 3'h0
`define FSP_MD_LOCK 3'h1
`define FSP_MD_PPB 3'h2
`define FSP_MD_DYB 3'h3
`define FSP_MD_FRZ 3'h4

// Lock register fields
`define FSP_LK_SSA 0
`define FSP_LK_PERS 1
`define FSP_LK_PW 2
`define FSP_LK_ERAOK 3
`define FSP_LK_DYBUP 4
`define FSP_LK_RSVD 11'h7ff
`define FSP_LK_FACTORY 5'h1f

// Sector memory fields
`define FSP_MB_DYB 0
`define FSP_MB_PPB 1

// Non-volatile operation time and its cycle count
`define FSP_CLK_NS 10
`define FSP_NVOP_NS 80
`define FSP_NVOP_CYC ((`FSP_NVOP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// file: rtl/fsp_protect.v
// What this block does
// - Five-bit non-volatile lock register, readable on data
// - Bit zero: 0 secured area locked, 1 unlocked
// - Bits one/two select persistent or password mode
// - Bit three 0 refuses erase-all-persistent command
// - Bit four sets dynamic bits power-up state
// - Bits fifteen to five always read ones
// - Programming both mode bits together aborts
// - Either mode bit programmed locks out other
// - Lock mode blocks bank 0, other reads allowed except during a lock program
// - No protection mode entry while suspended
// - Persistent bits program singly, erase all together
// - Persistent mode blocks bank 0, target, writes
// - Frozen persistent program/erase times out unchanged
// - Exit command returns read mode, reopens bank 0
// - Program/erase to protected sector ignored, read mode
// - Dynamic bit set/clear freely, no polling
// - Dynamic bit counts only with persistent bit one
// - Global freeze bit: 0 locks persistent bits
// - Only reset clears freeze outside password mode
// - Protected unless persistent and dynamic both one
// - Password mode freezes at reset; unlock clears it
`timescale 1ns/1ns
`include "fsp_map.vh"

module fsp_protect (
    input wire clk,
    input wire resetn,
    input wire nv_resetn,
    input wire ce,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [`FSP_SEC_W-1:0] cmd_sector,
    input wire [`FSP_BANK_W-1:0] cmd_bank,
    input wire [15:0] cmd_data,
    input wire pw_unlock,
    input wire pe_suspended,
    input wire acc_valid,
    input wire acc_write,
    input wire [`FSP_BANK_W-1:0] acc_bank,
    output reg busy,
    output reg rd_valid,
    output reg [15:0] rd_data,
    output reg op_fail,
    output reg arr_go,
    output reg [`FSP_SEC_W-1:0] arr_sector,
    output reg acc_grant,
    output reg [2:0] guard_mode,
    output reg freeze_open
);

localparam ST_INIT = 3'h0;
localparam ST_IDLE = 3'h1;
localparam ST_NVOP = 3'h2;
localparam ST_ERASE = 3'h3;
localparam ST_CHECK = 3'h4;
localparam ST_SREAD = 3'h5;

localparam PK_LOCK = 2'h0;
localparam PK_PPB = 2'h1;
localparam PK_ERASE = 2'h2;

localparam integer NVOP_INT = `FSP_NVOP_CYC;
localparam [7:0] NVOP_CYC = NVOP_INT[7:0];

reg [2:0] state;
reg [`FSP_SEC_W-1:0] walk;
reg [7:0] cnt;
reg [1:0] pend_kind;
reg [2:0] pend_mask;
reg [`FSP_SEC_W-1:0] pend_sector;
reg [`FSP_BANK_W-1:0] tgt_bank;
reg read_dyb;
reg [4:0] lock_nv;
reg lock_wr;

wire [1:0] mem_rdata;
reg mem_we;
reg [1:0] mem_wmask;
reg [`FSP_SEC_W-1:0] mem_waddr;
reg [1:0] mem_wdata;

wire take = (state == ST_IDLE) && cmd_valid;
wire pw_mode = ~lock_nv[`FSP_LK_PW];
wire is_enter = (cmd_op == `FSP_OP_ENTER_LOCK) ||
    (cmd_op == `FSP_OP_ENTER_PPB) ||
    (cmd_op == `FSP_OP_ENTER_DYB) ||
    (cmd_op == `FSP_OP_ENTER_FRZ);

// Bits to program to zero; factory bits three and four are never user set
wire [2:0] req_mask = ~cmd_data[2:0];
wire both_modes = req_mask[`FSP_LK_PERS] && req_mask[`FSP_LK_PW];
wire mode_clash = (req_mask[`FSP_LK_PERS] && pw_mode) ||
    (req_mask[`FSP_LK_PW] && ~lock_nv[`FSP_LK_PERS]);

// Sector protected unless persistent and dynamic both read one
wire sec_prot = ~mem_rdata[`FSP_MB_PPB] |
    ~mem_rdata[`FSP_MB_DYB];

wire nvop_end = (state == ST_NVOP) && (cnt == 8'h01);

// Non-volatile lock register, kept apart from the hardware reset
always @(posedge clk or negedge nv_resetn)
begin
    if (!nv_resetn)
        lock_nv <= `FSP_LK_FACTORY;
    else if (ce && lock_wr)
        lock_nv <= lock_nv & ~{2'b00, pend_mask};
end

always @*
begin
    lock_wr = nvop_end && (pend_kind == PK_LOCK);
    mem_we = 1'b0;
    mem_wmask = 2'b00;
    mem_waddr = cmd_sector;
    mem_wdata = 2'b00;
    case (state)
        ST_INIT:
        begin
            mem_we = 1'b1;
            mem_wmask = 2'b01;
            mem_waddr = walk;
            mem_wdata = {1'b0, lock_nv[`FSP_LK_DYBUP]};
        end
        ST_IDLE:
        begin
            if (take && guard_mode == `FSP_MD_DYB &&
                (cmd_op == `FSP_OP_DYB_SET || cmd_op == `FSP_OP_DYB_CLR))
            begin
                mem_we = 1'b1;
                mem_wmask = 2'b01;
                mem_wdata = {1'b0, cmd_op == `FSP_OP_DYB_CLR};
            end
        end
        ST_NVOP:
        begin
            if (nvop_end && pend_kind == PK_PPB && freeze_open)
            begin
                mem_we = 1'b1;
                mem_wmask = 2'b10;
                mem_waddr = pend_sector;
                mem_wdata = 2'b00;
            end
        end
        ST_ERASE:
        begin
            mem_we = 1'b1;
            mem_wmask = 2'b10;
            mem_waddr = walk;
            mem_wdata = 2'b10;
        end
        default:
        begin
            mem_we = 1'b0;
        end
    endcase
end

fsp_guard_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .wmask(mem_wmask),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(cmd_sector),
    .rdata(mem_rdata)
);

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        state <= ST_INIT;
        walk <= {`FSP_SEC_W{1'b0}};
        cnt <= 8'h00;
        pend_kind <= PK_LOCK;
        pend_mask <= 3'b000;
        pend_sector <= {`FSP_SEC_W{1'b0}};
        tgt_bank <= `FSP_BANK0;
        read_dyb <= 1'b0;
        busy <= 1'b1;
        rd_valid <= 1'b0;
        rd_data <= 16'h0000;
        op_fail <= 1'b0;
        arr_go <= 1'b0;
        arr_sector <= {`FSP_SEC_W{1'b0}};
        acc_grant <= 1'b0;
        guard_mode <= `FSP_MD_READ;
        freeze_open <= 1'b1;
    end
    else if (ce)
    begin
        rd_valid <= 1'b0;
        op_fail <= 1'b0;
        arr_go <= 1'b0;
        // A successful password unlock is the only software path to open
        if (pw_unlock && pw_mode)
            freeze_open <= 1'b1;
        case (state)
            ST_INIT:
            begin
                walk <= walk + 1'b1;
                if (walk == `FSP_SEC_LAST)
                begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                    if (pw_mode)
                        freeze_open <= 1'b0;
                end
            end
            ST_IDLE:
            begin
                if (take)
                begin
                    if (is_enter && pe_suspended)
                        op_fail <= 1'b1;
                    else
                    begin
                        case (cmd_op)
                            `FSP_OP_EXIT:
                                guard_mode <= `FSP_MD_READ;
                            `FSP_OP_ENTER_LOCK:
                                guard_mode <= `FSP_MD_LOCK;
                            `FSP_OP_ENTER_PPB:
                            begin
                                guard_mode <= `FSP_MD_PPB;
                                tgt_bank <= cmd_bank;
                            end
                            `FSP_OP_ENTER_DYB:
                                guard_mode <= `FSP_MD_DYB;
                            `FSP_OP_ENTER_FRZ:
                                guard_mode <= `FSP_MD_FRZ;
                            `FSP_OP_LOCK_PROG:
                            begin
                                if (guard_mode != `FSP_MD_LOCK ||
                                    both_modes || mode_clash)
                                    op_fail <= 1'b1;
                                else
                                begin
                                    pend_kind <= PK_LOCK;
                                    pend_mask <= req_mask;
                                    cnt <= NVOP_CYC;
                                    state <= ST_NVOP;
                                    busy <= 1'b1;
                                end
                            end
                            `FSP_OP_LOCK_READ:
                            begin
                                if (guard_mode == `FSP_MD_LOCK)
                                begin
                                    rd_valid <= 1'b1;
                                    rd_data <= {`FSP_LK_RSVD,
                                        lock_nv};
                                end
                            end
                            `FSP_OP_PPB_PROG,
                            `FSP_OP_PPB_ERASE:
                            begin
                                if (guard_mode != `FSP_MD_PPB)
                                    op_fail <= 1'b1;
                                else if (cmd_op == `FSP_OP_PPB_ERASE &&
                                    !lock_nv[`FSP_LK_ERAOK])
                                    op_fail <= 1'b1;
                                else
                                begin
                                    pend_kind <= (cmd_op == `FSP_OP_PPB_PROG)
                                        ? PK_PPB : PK_ERASE;
                                    pend_sector <= cmd_sector;
                                    cnt <= NVOP_CYC;
                                    state <= ST_NVOP;
                                    busy <= 1'b1;
                                end
                            end
                            `FSP_OP_PPB_READ,
                            `FSP_OP_DYB_READ:
                            begin
                                if ((cmd_op == `FSP_OP_PPB_READ &&
                                    guard_mode == `FSP_MD_PPB) ||
                                    (cmd_op == `FSP_OP_DYB_READ &&
                                    guard_mode == `FSP_MD_DYB))
                                begin
                                    read_dyb <= (cmd_op == `FSP_OP_DYB_READ);
                                    state <= ST_SREAD;
                                    busy <= 1'b1;
                                end
                            end
                            `FSP_OP_FRZ_SET:
                            begin
                                if (guard_mode == `FSP_MD_FRZ)
                                    freeze_open <= 1'b0;
                            end
                            `FSP_OP_FRZ_READ:
                            begin
                                if (guard_mode == `FSP_MD_FRZ)
                                begin
                                    rd_valid <= 1'b1;
                                    rd_data <= {15'h0000, freeze_open};
                                end
                            end
                            `FSP_OP_ARRAY_PE:
                            begin
                                if (guard_mode == `FSP_MD_READ)
                                begin
                                    pend_sector <= cmd_sector;
                                    state <= ST_CHECK;
                                    busy <= 1'b1;
                                end
                                else
                                    op_fail <= 1'b1;
                            end
                            default:
                                guard_mode <= guard_mode;
                        endcase
                    end
                end
            end
            ST_NVOP:
            begin
                cnt <= cnt - 1'b1;
                if (nvop_end)
                begin
                    if (pend_kind == PK_ERASE && freeze_open)
                    begin
                        walk <= {`FSP_SEC_W{1'b0}};
                        state <= ST_ERASE;
                    end
                    else
                    begin
                        // Frozen persistent work ends as a timeout
                        if (pend_kind != PK_LOCK && !freeze_open)
                            op_fail <= 1'b1;
                        state <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
            end
            ST_ERASE:
            begin
                walk <= walk + 1'b1;
                if (walk == `FSP_SEC_LAST)
                begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            end
            ST_CHECK:
            begin
                state <= ST_IDLE;
                busy <= 1'b0;
                if (sec_prot)
                    op_fail <= 1'b1;
                else
                begin
                    arr_go <= 1'b1;
                    arr_sector <= pend_sector;
                end
            end
            ST_SREAD:
            begin
                state <= ST_IDLE;
                busy <= 1'b0;
                rd_valid <= 1'b1;
                rd_data <= {15'h0000, read_dyb ? mem_rdata[`FSP_MB_DYB]
                    : mem_rdata[`FSP_MB_PPB]};
            end
            default:
            begin
                state <= ST_IDLE;
                busy <= 1'b0;
            end
        endcase
        // Array access gating by mode; the host still sees a clean refusal
        if (!acc_valid || state == ST_INIT)
            acc_grant <= 1'b0;
        else if (guard_mode == `FSP_MD_LOCK)
            acc_grant <= acc_bank != `FSP_BANK0 && !acc_write &&
                !(state == ST_NVOP && pend_kind == PK_LOCK);
        else if (guard_mode == `FSP_MD_PPB)
            acc_grant <= acc_bank != `FSP_BANK0 && acc_bank != tgt_bank &&
                !acc_write;
        else
            acc_grant <= 1'b1;
    end
end

endmodule

// file: sim/fsp_host.sv
`timescale 1ns/1ns
`include "fsp_map.vh"
module fsp_host (
    input wire clk,
    input wire busy,
    input wire rd_valid,
    input wire [15:0] rd_data,
    input wire op_fail,
    input wire arr_go,
    input wire acc_grant,
    output reg cmd_valid,
    output reg [3:0] cmd_op,
    output reg [`FSP_SEC_W-1:0] cmd_sector,
    output reg [`FSP_BANK_W-1:0] cmd_bank,
    output reg [15:0] cmd_data,
    output reg acc_valid,
    output reg acc_write,
    output reg [`FSP_BANK_W-1:0] acc_bank
);
    reg fl;
    reg go;
    reg gr;
    reg [15:0] rdat;
    integer k;
    integer q;
    initial
    begin
        {cmd_valid, cmd_op, cmd_sector, cmd_bank, cmd_data} = 34'h0;
        {acc_valid, acc_write, acc_bank} = 6'h0;
    end
    task send(input [3:0] op, input [8:0] s, input [3:0] b,
        input [15:0] d);
    begin
        @(negedge clk);
        cmd_valid = 1'b1;
        {cmd_op, cmd_sector, cmd_bank, cmd_data} = {op, s, b, d};
        k = 0;
        while (busy && k < 1200)
        begin
            @(negedge clk);
            k = k + 1;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        // Released lines show the inverse, never a stale value
        {cmd_op, cmd_sector, cmd_bank, cmd_data} = ~{op, s, b, d};
        {fl, go, q, k} = {2'b00, 32'd0, 32'd0};
        // Status polled until busy has stayed low for three cycles
        while (q < 3 && k < 1200)
        begin
            fl = fl | op_fail;
            go = go | arr_go;
            if (rd_valid)
                rdat = rd_data;
            q = busy ? 0 : q + 1;
            k = k + 1;
            @(negedge clk);
        end
    end
    endtask
    // One-shot reads or writes, issued only between commands
    task access(input [3:0] b, input w);
    begin
        @(negedge clk);
        {acc_valid, acc_write, acc_bank} = {1'b1, w, b};
        @(negedge clk);
        gr = acc_grant;
        {acc_valid, acc_write, acc_bank} = {1'b0, ~w, ~b};
    end
    endtask
endmodule

// file: sim/fsp_protect_assertions.sv
`timescale 1ns/1ns
`include "fsp_map.vh"
module fsp_protect_assertions (
    input wire clk,
    input wire resetn,
    input wire nv_resetn,
    input wire ce,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [`FSP_SEC_W-1:0] cmd_sector,
    input wire [`FSP_BANK_W-1:0] cmd_bank,
    input wire [15:0] cmd_data,
    input wire pw_unlock,
    input wire pe_suspended,
    input wire acc_valid,
    input wire acc_write,
    input wire [`FSP_BANK_W-1:0] acc_bank,
    input wire busy,
    input wire rd_valid,
    input wire [15:0] rd_data,
    input wire op_fail,
    input wire arr_go,
    input wire [`FSP_SEC_W-1:0] arr_sector,
    input wire acc_grant,
    input wire [2:0] guard_mode,
    input wire freeze_open
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire taken = ce && cmd_valid && !busy;
    wire enter = taken && (cmd_op == `FSP_OP_ENTER_LOCK ||
        cmd_op == `FSP_OP_ENTER_PPB || cmd_op == `FSP_OP_ENTER_DYB ||
        cmd_op == `FSP_OP_ENTER_FRZ);
    wire pe_cmd = taken && cmd_op == `FSP_OP_ARRAY_PE;
    // Grants are only owed once the power-up walk has finished
    reg ready;
    always @(posedge clk or negedge resetn)
        if (!resetn)
            ready <= 1'b0;
        else if (!busy)
            ready <= 1'b1;

    a_go_cause: assert property (arr_go |-> $past(pe_cmd, 2))
        else $error("array go without a command");
    a_go_sector: assert property (
        arr_go |-> arr_sector == $past(cmd_sector, 2))
        else $error("array go for wrong sector");
    a_go_mode: assert property (
        pe_cmd && guard_mode != `FSP_MD_READ |=> op_fail && !arr_go)
        else $error("array command outside read mode");
    a_lock_word: assert property (
        taken && cmd_op == `FSP_OP_LOCK_READ && guard_mode == `FSP_MD_LOCK
        |=> rd_valid && rd_data[15:5] == `FSP_LK_RSVD)
        else $error("reserved lock bits not ones");
    a_lock_bank0: assert property (
        guard_mode == `FSP_MD_LOCK && acc_valid && acc_bank == `FSP_BANK0
        |=> !acc_grant)
        else $error("bank 0 granted in lock mode");
    a_ppb_bank0: assert property (
        guard_mode == `FSP_MD_PPB && acc_valid && acc_bank == `FSP_BANK0
        |=> !acc_grant)
        else $error("bank 0 granted in persistent mode");
    a_read_grant: assert property (
        ready && !busy && acc_valid && guard_mode == `FSP_MD_READ
        |=> acc_grant)
        else $error("access refused in read mode");
    a_suspend_refuse: assert property (
        enter && pe_suspended |=> op_fail)
        else $error("mode entry taken while suspended");
    a_freeze_hold: assert property (
        !freeze_open && !pw_unlock |=> !freeze_open)
        else $error("freeze bit cleared by command");
    a_frozen_fail: assert property (
        taken && !freeze_open && guard_mode == `FSP_MD_PPB &&
        cmd_op == `FSP_OP_PPB_ERASE |-> ##[1:12] op_fail)
        else $error("frozen erase did not time out");
    c_go: cover property (arr_go);
    c_fail: cover property (op_fail);
    c_read: cover property (rd_valid);
endmodule

// file: sim/fsp_protect_tb.sv
`timescale 1ns/1ns
`include "fsp_map.vh"
module fsp_protect_tb;
    reg clk;
    reg resetn;
    reg nv_resetn;
    reg ce;
    reg pw_unlock;
    reg pe_suspended;
    wire cmd_valid, acc_valid, acc_write, busy, rd_valid, op_fail, arr_go;
    wire acc_grant, freeze_open;
    wire [3:0] cmd_op, cmd_bank, acc_bank;
    wire [8:0] cmd_sector, arr_sector;
    wire [15:0] cmd_data, rd_data;
    wire [2:0] guard_mode;
    integer failures;
    integer check_count;
    integer i;
    reg [31:0] seed;
    reg [8:0] s1;
    reg [8:0] s2;
    fsp_protect i_dut (.clk(clk), .resetn(resetn), .nv_resetn(nv_resetn),
        .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_sector(cmd_sector), .cmd_bank(cmd_bank), .cmd_data(cmd_data),
        .pw_unlock(pw_unlock), .pe_suspended(pe_suspended),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_bank(acc_bank),
        .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
        .op_fail(op_fail), .arr_go(arr_go), .arr_sector(arr_sector),
        .acc_grant(acc_grant), .guard_mode(guard_mode),
        .freeze_open(freeze_open));
    fsp_host i_host (.clk(clk), .busy(busy), .rd_valid(rd_valid),
        .rd_data(rd_data), .op_fail(op_fail), .arr_go(arr_go),
        .acc_grant(acc_grant), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_sector(cmd_sector), .cmd_bank(cmd_bank), .cmd_data(cmd_data),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_bank(acc_bank));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
    begin
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    end
    endfunction
    function prot(input persistent_sector_guard, input dynamic_sector_guard);
        prot = !(persistent_sector_guard && dynamic_sector_guard);
    endfunction
    function [15:0] lock_word(input [4:0] lk);
        lock_word = {`FSP_LK_RSVD, lk};
    endfunction
    task chk_bit(input got, input exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error %0t flag %b expected %b", $time, got, exp);
        end
    end
    endtask
    task chk_word(input [15:0] got, input [15:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error %0t word %h expected %h", $time, got, exp);
        end
    end
    endtask
    task test_done;
    begin
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task cmd(input [3:0] op, input [8:0] s);
        i_host.send(op, s, 4'h3, 16'hffff);
    endtask
    task reboot;
    begin
        resetn = 1'b0;
        repeat (5) @(negedge clk);
        {resetn, nv_resetn} = 2'b11;
        i = 0;
        while (busy && i < 1000)
        begin
            @(negedge clk);
            i = i + 1;
        end
    end
    endtask
    task pe(input [8:0] s, input p);
    begin
        cmd(`FSP_OP_ARRAY_PE, s);
        chk_bit(i_host.go, !p);
        chk_bit(i_host.fl, p);
        if (!p)
            chk_word({7'h0, arr_sector}, {7'h0, s});
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        failures = failures + 1;
        test_done;
    end
    initial
    begin
        {failures, check_count, seed} = {32'd0, 32'd0, 32'h6da56f4c};
        {resetn, nv_resetn, ce, pw_unlock, pe_suspended} = 5'b00100;
        reboot;
        chk_bit(freeze_open, 1'b1);
        cmd(`FSP_OP_ENTER_LOCK, 9'h0);
        chk_word({13'h0, guard_mode}, {13'h0, `FSP_MD_LOCK});
        cmd(`FSP_OP_LOCK_READ, 9'h0);
        chk_word(i_host.rdat, lock_word(`FSP_LK_FACTORY));
        i_host.access(`FSP_BANK0, 1'b0);
        chk_bit(i_host.gr, 1'b0);
        i_host.access(4'h5, 1'b0);
        chk_bit(i_host.gr, 1'b1);
        i_host.send(`FSP_OP_LOCK_PROG, 9'h0, 4'h0, 16'hfff9);
        chk_bit(i_host.fl, 1'b1);
        i_host.send(`FSP_OP_LOCK_PROG, 9'h0, 4'h0, 16'hfffd);
        chk_bit(i_host.fl, 1'b0);
        cmd(`FSP_OP_LOCK_READ, 9'h0);
        chk_word(i_host.rdat, lock_word(5'h1d));
        i_host.send(`FSP_OP_LOCK_PROG, 9'h0, 4'h0, 16'hfffb);
        chk_bit(i_host.fl, 1'b1);
        cmd(`FSP_OP_ENTER_PPB, 9'h0);
        cmd(`FSP_OP_PPB_ERASE, 9'h0);
        chk_bit(i_host.fl, 1'b0);
        i_host.access(`FSP_BANK0, 1'b0);
        chk_bit(i_host.gr, 1'b0);
        i_host.access(4'h3, 1'b0);
        chk_bit(i_host.gr, 1'b0);
        seed = xs(seed);
        i_host.access(4'h4 | seed[1:0], 1'b0);
        chk_bit(i_host.gr, 1'b1);
        s1 = seed[8:0];
        s2 = s1 ^ (seed[20:12] | 9'h1);
        cmd(`FSP_OP_PPB_PROG, s1);
        chk_bit(i_host.fl, 1'b0);
        cmd(`FSP_OP_PPB_READ, s1);
        chk_word(i_host.rdat, 16'h0000);
        cmd(`FSP_OP_EXIT, 9'h0);
        chk_word({13'h0, guard_mode}, {13'h0, `FSP_MD_READ});
        i_host.access(`FSP_BANK0, 1'b1);
        chk_bit(i_host.gr, 1'b1);
        pe(s1, prot(1'b0, 1'b1));
        pe(s2, prot(1'b1, 1'b1));
        cmd(`FSP_OP_ENTER_DYB, 9'h0);
        cmd(`FSP_OP_DYB_CLR, s1);
        cmd(`FSP_OP_DYB_READ, s1);
        chk_word(i_host.rdat, 16'h0001);
        cmd(`FSP_OP_ARRAY_PE, s2);
        chk_bit(i_host.fl, 1'b1);
        cmd(`FSP_OP_EXIT, 9'h0);
        pe(s1, prot(1'b0, 1'b1));
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = xs(seed);
            cmd(`FSP_OP_ENTER_DYB, 9'h0);
            cmd(seed[0] ? `FSP_OP_DYB_CLR : `FSP_OP_DYB_SET, s2);
            cmd(`FSP_OP_EXIT, 9'h0);
            pe(s2, prot(1'b1, seed[0]));
        end
        cmd(`FSP_OP_ENTER_FRZ, 9'h0);
        cmd(`FSP_OP_FRZ_SET, 9'h0);
        chk_bit(freeze_open, 1'b0);
        cmd(`FSP_OP_FRZ_READ, 9'h0);
        chk_word(i_host.rdat, 16'h0000);
        cmd(`FSP_OP_ENTER_PPB, 9'h0);
        cmd(`FSP_OP_PPB_ERASE, 9'h0);
        chk_bit(i_host.fl, 1'b1);
        cmd(`FSP_OP_EXIT, 9'h0);
        pe(s1, 1'b1);
        pe_suspended = 1'b1;
        cmd(`FSP_OP_ENTER_LOCK, 9'h0);
        chk_bit(i_host.fl, 1'b1);
        pe_suspended = 1'b0;
        pw_unlock = 1'b1;
        @(negedge clk);
        pw_unlock = 1'b0;
        @(negedge clk);
        chk_bit(freeze_open, 1'b0);
        reboot;
        chk_bit(freeze_open, 1'b1);
        pe(s1, 1'b1);
        pe(s2, prot(1'b1, 1'b1));
        test_done;
    end
endmodule
bind fsp_protect fsp_protect_assertions i_chk (.clk(clk), .resetn(resetn),
    .nv_resetn(nv_resetn), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_sector(cmd_sector), .cmd_bank(cmd_bank), .cmd_data(cmd_data),
    .pw_unlock(pw_unlock), .pe_suspended(pe_suspended),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_bank(acc_bank),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
    .op_fail(op_fail), .arr_go(arr_go), .arr_sector(arr_sector),
    .acc_grant(acc_grant), .guard_mode(guard_mode),
    .freeze_open(freeze_open));
